// ===== src/asc_scaler.sv
// Purpose: analog speed command scaler with Avalon-MM register access
// Assumes: converter samples are synchronous to clk, read at each smoothing tick
// Notes:   demand updates in a short pipeline after each smoothing tick
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Operation
// - the demand is zero while the input lies inside the dead band around the offset.
// - input above the offset gives a positive demand and below it a negative one.
// - the span from offset plus dead band to full scale maps onto 2047 counts; the code maps 8191 counts past the dead band onto 2047 instead.
// - the demand is the speed gain times the conditioned count.
// - rpm equals 1875 times demand over 512 times encoder resolution.
// - the dead band setting uses 8191 counts for 10 V.
// - the offset setting uses 8191 counts for 10 V and is signed.
// - writing 1 to the save command stores parameters, writing 10 restores defaults.
// - source select 0 disables, 1 picks input one, 2 picks input two.
// - the input is smoothed with time constant setting over 4000 seconds.
module asc_scaler
  import asc_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [ASC_ADDR_W-1:0]          avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic [31:0]                         avs_readdata,
  output logic                                avs_waitrequest,
  output logic [1:0]                          avs_response,
  input  wire logic signed [ASC_SAMPLE_W-1:0] analog_input_one,
  input  wire logic signed [ASC_SAMPLE_W-1:0] analog_input_two,
  output logic signed [ASC_DEMAND_W-1:0]      speed_demand,
  output logic                                demand_valid,
  output logic                                store_request
);

  localparam int CW = 12;

  asc_params_t              live;
  asc_params_t              saved;
  asc_state_t               state;
  logic [15:0]              div_cnt;
  logic                     tick;
  logic                     tick_late;
  logic signed [ASC_SAMPLE_W-1:0] smoothed;
  logic signed [ASC_SAMPLE_W-1:0] selected;
  logic signed [17:0]       shifted;
  logic [17:0]              mag;
  logic                     neg;
  logic signed [CW-1:0]     cond;
  logic [31:0]              scaled_num;
  logic                     acc_pending;
  logic                     save_busy;
  logic [31:0]              next_readdata;
  logic                     addr_ok;

  // byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // smoothing tick divider
  always_ff @(posedge clk) begin
    if (!rst_n || div_cnt == 16'(ASC_SMOOTH_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    tick <= rst_n && (div_cnt == 16'(ASC_SMOOTH_DIV - 1));
  end

  // pipeline starts one cycle after the filter step so it sees the new sample
  always_ff @(posedge clk) begin
    tick_late <= rst_n && tick;
  end

  always_comb begin
    case (live.source)
      ASC_SRC_ANALOG_INPUT_ONE: selected = analog_input_one;
      ASC_SRC_ANALOG_INPUT_TWO: selected = analog_input_two;
      default:      selected = '0;
    endcase
  end

  asc_smoother #(
    .W (ASC_SAMPLE_W)
  ) u_smooth (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .clear    (live.source == ASC_SRC_OFF),
    .setting  (live.smooth),
    .sample   (selected),
    .smoothed (smoothed)
  );

  // register access: one wait cycle then answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_pending <= 1'b0;
    end else begin
      acc_pending <= (avs_read || avs_write) && !acc_pending;
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    case (avs_address)
      ASC_OFS_SAVE:   next_readdata = {31'h0, save_busy};
      ASC_OFS_DEAD:   next_readdata = {16'h0, live.dead};
      ASC_OFS_OFFSET: next_readdata = {{16{live.offset[15]}}, live.offset};
      ASC_OFS_GAIN:   next_readdata = {16'h0, live.gain};
      ASC_OFS_SOURCE: next_readdata = {30'h0, live.source};
      ASC_OFS_SMOOTH: next_readdata = {16'h0, live.smooth};
      ASC_OFS_DEMAND: next_readdata = speed_demand;
      ASC_OFS_COND:   next_readdata = 32'(cond);
      ASC_OFS_STATUS: next_readdata = {30'h0, state};
      default: begin
        next_readdata = 32'h0;
        addr_ok       = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      avs_response    <= 2'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !acc_pending);
      avs_readdata    <= avs_read ? next_readdata : 32'h0;
      avs_response    <= addr_ok ? 2'h0 : 2'h3;
    end
  end

  wire wr_take = avs_write && acc_pending;

  // parameter registers, store and restore
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      live  <= '{ASC_RST_DEAD, ASC_RST_OFFSET, ASC_RST_GAIN, ASC_RST_SMOOTH, ASC_RST_SOURCE};
      saved <= '{ASC_RST_DEAD, ASC_RST_OFFSET, ASC_RST_GAIN, ASC_RST_SMOOTH, ASC_RST_SOURCE};
      save_busy     <= 1'b0;
      store_request <= 1'b0;
    end else begin
      store_request <= 1'b0;
      save_busy     <= 1'b0;
      if (wr_take) begin
        case (avs_address)
          ASC_OFS_SAVE: begin
            if (merge16(16'h0, avs_writedata, avs_byteenable) == ASC_CMD_STORE) begin
              saved         <= live;
              store_request <= 1'b1;
              save_busy     <= 1'b1;
            end else if (merge16(16'h0, avs_writedata, avs_byteenable) == ASC_CMD_INIT) begin
              live <= '{ASC_RST_DEAD, ASC_RST_OFFSET, ASC_RST_GAIN,
                        ASC_RST_SMOOTH, ASC_RST_SOURCE};
              save_busy <= 1'b1;
            end
          end
          ASC_OFS_DEAD:   live.dead   <= merge16(live.dead, avs_writedata, avs_byteenable);
          ASC_OFS_OFFSET: live.offset <= merge16(live.offset, avs_writedata, avs_byteenable);
          ASC_OFS_GAIN:   live.gain   <= merge16(live.gain, avs_writedata, avs_byteenable);
          ASC_OFS_SMOOTH: live.smooth <= merge16(live.smooth, avs_writedata, avs_byteenable);
          ASC_OFS_SOURCE: begin
            if (avs_byteenable[0] && avs_writedata[7:0] <= 8'h02) begin
              live.source <= avs_writedata[1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // conditioning pipeline: shift, dead band, scale, gain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= ASC_IDLE;
      shifted      <= '0;
      mag          <= '0;
      neg          <= 1'b0;
      cond         <= '0;
      scaled_num   <= '0;
      speed_demand <= '0;
      demand_valid <= 1'b0;
    end else begin
      demand_valid <= 1'b0;
      case (state)
        ASC_IDLE: begin
          if (tick_late) begin
            // offset in the same 8191-per-10V counts as the sample
            shifted <= 18'(smoothed) - 18'($signed(live.offset));
            state   <= ASC_SHIFT;
          end
        end
        ASC_SHIFT: begin
          neg <= shifted[17];
          if ((shifted[17] ? 18'(-shifted) : 18'(shifted)) <= 18'(live.dead)) begin
            mag <= '0;
          end else begin
            mag <= (shifted[17] ? 18'(-shifted) : 18'(shifted)) - 18'(live.dead);
          end
          state <= ASC_SCALE;
        end
        ASC_SCALE: begin
          // 8191 counts past the dead band map onto 2047, whatever the offset and dead band
          scaled_num <= 32'(mag) * 32'(ASC_COND_FULL) / 32'(ASC_FULL_COUNTS);
          state      <= ASC_OUTPUT;
        end
        ASC_OUTPUT: begin
          if (live.source == ASC_SRC_OFF) begin
            cond         <= '0;
            speed_demand <= '0;
          end else begin
            cond <= neg ? -CW'(scaled_num) : CW'(scaled_num);
            // demand in encoder units; rpm = 1875*demand/(512*resolution)
            speed_demand <= neg ? -($signed({16'h0, live.gain}) * $signed(scaled_num))
                                : $signed({16'h0, live.gain}) * $signed(scaled_num);
          end
          demand_valid <= 1'b1;
          state        <= ASC_IDLE;
        end
        default: state <= ASC_IDLE;
      endcase
    end
  end

endmodule

// ===== src/asc_pkg.sv
// Purpose: shared constants and types for the analog speed command scaler
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   converter samples arrive as signed counts, 8191 counts for 10 V
package asc_pkg;

  localparam int ASC_SAMPLE_W   = 14;
  localparam int ASC_PARAM_W    = 16;
  localparam int ASC_DEMAND_W   = 32;
  localparam int ASC_ADDR_W     = 6;

  // register byte offsets
  localparam logic [5:0] ASC_OFS_SAVE     = 6'h00;
  localparam logic [5:0] ASC_OFS_DEAD     = 6'h04;
  localparam logic [5:0] ASC_OFS_OFFSET   = 6'h08;
  localparam logic [5:0] ASC_OFS_GAIN     = 6'h0C;
  localparam logic [5:0] ASC_OFS_SOURCE   = 6'h10;
  localparam logic [5:0] ASC_OFS_SMOOTH   = 6'h14;
  localparam logic [5:0] ASC_OFS_DEMAND   = 6'h18;
  localparam logic [5:0] ASC_OFS_COND     = 6'h1C;
  localparam logic [5:0] ASC_OFS_STATUS   = 6'h20;

  // scaling constants
  localparam int ASC_FULL_COUNTS  = 8191;
  localparam int ASC_COND_FULL    = 2047;
  localparam int ASC_RPM_NUM      = 1875;
  localparam int ASC_RPM_DEN      = 512;
  localparam int ASC_SMOOTH_RATE  = 4000;

  // save command codes
  localparam logic [15:0] ASC_CMD_STORE = 16'h0001;
  localparam logic [15:0] ASC_CMD_INIT  = 16'h000A;

  // speed source select codes
  localparam logic [1:0] ASC_SRC_OFF  = 2'h0;
  localparam logic [1:0] ASC_SRC_ANALOG_INPUT_ONE = 2'h1;
  localparam logic [1:0] ASC_SRC_ANALOG_INPUT_TWO = 2'h2;

  // defaults
  localparam logic [15:0] ASC_RST_DEAD   = 16'h0000;
  localparam logic [15:0] ASC_RST_OFFSET = 16'h0000;
  localparam logic [15:0] ASC_RST_GAIN   = 16'h0FA0;
  localparam logic [15:0] ASC_RST_SMOOTH = 16'h0005;
  localparam logic [1:0]  ASC_RST_SOURCE = 2'h0;

  // timing: clock rate in Hz and smoothing tick divider in clock cycles
  localparam longint ASC_CLK_HZ       = 125000000;
  localparam int     ASC_SMOOTH_DIV   = int'(ASC_CLK_HZ / ASC_SMOOTH_RATE);

  typedef struct packed {
    logic [15:0] dead;
    logic [15:0] offset;
    logic [15:0] gain;
    logic [15:0] smooth;
    logic [1:0]  source;
  } asc_params_t;

  typedef enum logic [1:0] {
    ASC_IDLE   = 2'b00,
    ASC_SHIFT  = 2'b01,
    ASC_SCALE  = 2'b10,
    ASC_OUTPUT = 2'b11
  } asc_state_t;

endpackage

// ===== src/asc_smoother.sv
// Purpose: first-order low-pass on the selected sample
// Assumes: tick is a one-cycle pulse at the smoothing rate
// Notes:   y += (x - y) / n with n the smoothing setting, n clamped to 1..127
`timescale 1ns/1ps
module asc_smoother
  import asc_pkg::*;
#(
  parameter int W = ASC_SAMPLE_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                tick,
  input  wire logic                clear,
  input  wire logic [15:0]         setting,
  input  wire logic signed [W-1:0] sample,
  output logic signed [W-1:0]      smoothed
);

  // extra fraction bits keep small steps from stalling the filter
  localparam int FW = W + 8;

  logic signed [FW-1:0] acc;
  logic signed [FW-1:0] diff;
  logic [6:0]           n;

  always_comb begin
    n = (setting == 16'h0000) ? 7'h01 :
        (setting > 16'h007F) ? 7'h7F : setting[6:0];
    diff = {sample, 8'h00} - acc;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      acc <= '0;
    end else if (tick) begin
      acc <= acc + FW'(diff / $signed({1'b0, n}));
    end
  end

  assign smoothed = acc[FW-1:8];

endmodule

// ===== tb/asc_chk_sva.sv
// Purpose: port checker for the speed command scaler
// Assumes: one wait cycle per bus request, pulses one cycle wide
// Notes:   bound below to every asc_scaler
`timescale 1ns/1ps
module asc_chk
  import asc_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [5:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic [1:0]         avs_response,
  input wire logic signed [31:0] speed_demand,
  input wire logic               demand_valid,
  input wire logic               store_request
);
  wire req      = avs_read | avs_write;
  wire save_one = avs_write & (avs_address == ASC_OFS_SAVE) & (avs_writedata[15:0] == ASC_CMD_STORE);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_new_req; req && !$past(req); endsequence
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  a_wait_one: assert property (s_new_req |-> s_one_wait)
    else $error("bus answer timing wrong");
  a_ack_cause: assert property (!avs_waitrequest |-> req && $past(req))
    else $error("answer without request");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address > ASC_OFS_STATUS
    |-> avs_response == 2'h3 && avs_readdata == 32'h0) else $error("unmapped read answer");
  a_mapped_ok: assert property (!avs_waitrequest && avs_address <= ASC_OFS_STATUS
    |-> avs_response == 2'h0) else $error("mapped access refused");
  a_valid_gap: assert property (demand_valid |=> !demand_valid [*8])
    else $error("demand update pulse too long");
  a_demand_hold: assert property ($changed(speed_demand) |-> demand_valid)
    else $error("demand moved without update");
  a_store_pulse: assert property (store_request |=> !store_request)
    else $error("store pulse too long");
  a_store_cause: assert property (store_request |-> $past(save_one) || $past(save_one, 2))
    else $error("store pulse without save command");
endmodule
bind asc_scaler asc_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .speed_demand(speed_demand), .demand_valid(demand_valid), .store_request(store_request));

// ===== tb/asc_src_model.sv
// Purpose: analog command source as seen through the converter
// Assumes: samples change just after clk like a converter output
// Notes:   the unused input wanders every cycle so it is never mistaken
`timescale 1ns/1ps
module asc_src_model (
  input  wire logic signed [13:0] level,
  input  wire logic               clk,
  output logic signed [13:0]      in_one,
  output logic signed [13:0]      in_two
);
  initial in_two = 14'h1555;
  always @(posedge clk) begin
    in_one <= level;
    in_two <= in_two + 14'h00F3;
  end
endmodule

// ===== tb/asc_scaler_tb.sv
// Purpose: self-checking bench for the speed command scaler
// Assumes: three demand updates fit within the run
// Notes:   smoothing set to 1 so each update follows the input exactly
`timescale 1ns/1ps
module asc_scaler_tb
  import asc_pkg::*;
;
  localparam int OFF = -819;
  localparam int DEAD = 409;
  localparam int GAIN = 4708;
  logic               clk;
  logic               rst_n;
  logic [5:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [1:0]         avs_response;
  logic signed [13:0] level;
  logic signed [13:0] in_one;
  logic signed [13:0] in_two;
  logic signed [31:0] speed_demand;
  logic               demand_valid;
  logic               store_request;
  logic signed [31:0] notes[$];
  logic [31:0]        seed;
  logic [31:0]        q;
  logic [1:0]         resp;
  int                 miscompares;
  int                 checks_done;
  int                 cycles;
  int                 updates;
  int                 stores;
  int                 x;
  logic [5:0]         ra [4] = '{ASC_OFS_DEAD, ASC_OFS_OFFSET, ASC_OFS_GAIN, ASC_OFS_SMOOTH};
  logic [15:0]        rv [4] = '{ASC_RST_DEAD, ASC_RST_OFFSET, ASC_RST_GAIN, ASC_RST_SMOOTH};
  logic [31:0]        wv [4] = '{32'h0199, 32'hFCCD, 32'h1264, 32'h0001};
  asc_scaler dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .analog_input_one(in_one), .analog_input_two(in_two), .speed_demand(speed_demand),
    .demand_valid(demand_valid), .store_request(store_request));
  asc_src_model src (.level(level), .clk(clk), .in_one(in_one), .in_two(in_two));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // offset first, then dead band, then span scaling and gain
  function automatic int dem(input int v);
    int m;
    int c;
    m = (v < OFF) ? OFF - v : v - OFF;
    c = (m > DEAD) ? (m - DEAD) * ASC_COND_FULL / ASC_FULL_COUNTS : 0;
    return (v < OFF) ? -c * GAIN : c * GAIN;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, e, q);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 99000) begin
      miscompares++;
      wrap_up();
    end
  end
  always @(posedge clk) begin
    if (store_request === 1'b1) stores++;
    if (demand_valid === 1'b1) begin
      updates++;
      chk("demand", notes.pop_front(), speed_demand);
    end
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    level = 14'h0000;
    seed = 32'hb5e6;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ra[i], {16'h0, rv[i]}, "reset value");
    rd(ASC_OFS_SOURCE, 32'h0, "reset source");
    rd(6'h24, 32'h0, "unmapped read");
    chk("unmapped response", 32'h3, {30'h0, resp});
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) bus(1'b1, ra[i], wv[i]);
    for (int i = 0; i < 4; i++) rd(ra[i], i == 1 ? 32'hFFFFFCCD : wv[i], "readback");
    bus(1'b1, ASC_OFS_SOURCE, 32'h1);
    bus(1'b1, ASC_OFS_SOURCE, 32'h3);
    rd(ASC_OFS_SOURCE, 32'h1, "source");
    bus(1'b1, ASC_OFS_SAVE, 32'h1);
    repeat (2) @(posedge clk);
    chk("store pulse", 32'h1, stores);
    $display("test config done");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      x = k == 0 ? 5000 + int'(seed % 2000) : k == 1 ? OFF - DEAD + int'(seed % 819)
        : OFF - 1000 - int'(seed % 1000);
      level <= 14'(x);
      notes.push_back(32'(dem(x)));
      wait (updates == k + 1);
      rd(ASC_OFS_DEMAND, 32'(dem(x)), "demand register");
      rd(ASC_OFS_COND, 32'(dem(x) / GAIN), "conditioned count");
      $display("test update %0d done", k);
    end
    bus(1'b1, ASC_OFS_SAVE, 32'hA);
    rd(ASC_OFS_GAIN, {16'h0, ASC_RST_GAIN}, "gain after init");
    chk("no store on init", 32'h1, stores);
    $display("test init done");
    wrap_up();
  end
endmodule
